// file: src/fts_top.sv
`timescale 1ns/10ps
`include "fts_params.svh"


module fts_top (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     sleep_request,
  input  wire logic                     chip_select_1_n,
  input  wire logic                     chip_select_2,
  input  wire logic                     chip_select_3_n,
  input  wire logic                     advance_or_load_n,
  input  wire logic                     write_enable_n,
  input  wire logic [`FTS_LANES-1:0]    byte_lane_selects_n,
  input  wire logic                     clock_qualify_n,
  input  wire logic                     output_enable_n,
  input  wire logic                     burst_order,
  input  wire logic [`FTS_ADDR_W-1:0]   address,
  input  wire logic [`FTS_DQ_W-1:0]     dq_i,
  output logic      [`FTS_DQ_W-1:0]     dq_o,
  output logic                          dq_oe,
  input  wire logic [`FTS_LANES-1:0]    parity_io_i,
  output logic      [`FTS_LANES-1:0]    parity_io_o,
  output logic                          parity_io_oe,
  output logic                          sleep_active
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic selects_on(input fts_pkg::fts_ctrl_s c);
    selects_on = !c.cs1_n && c.cs2 && !c.cs3_n;
  endfunction

  // ****************************************
  // reset release and sleep synchroniser
  // ****************************************
  logic [`FTS_RST_STAGES-1:0]  rst_pipe_q;
  logic                        rst_n;
  logic [`FTS_SLEEP_CYC-1:0]   sleep_sync_q;
  logic                        asleep;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe_q <= '0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[`FTS_RST_STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_q[`FTS_RST_STAGES-1];

  // two flops double as the two-cycle entry and exit delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync_q <= '0;
    end else begin
      sleep_sync_q <= {sleep_sync_q[`FTS_SLEEP_CYC-2:0], sleep_request};
    end
  end

  assign asleep       = sleep_sync_q[`FTS_SLEEP_CYC-1];
  assign sleep_active = asleep;

  // ****************************************
  // cycle decode
  // ****************************************
  fts_pkg::fts_ctrl_s          ctrl;
  fts_pkg::fts_cycle_s         cur_q;
  fts_pkg::fts_cycle_s         cur_d;
  fts_pkg::fts_cycle_s         load_cyc;
  fts_pkg::fts_cycle_s         cont_cyc;
  fts_pkg::fts_cycle_s         next_cyc;
  fts_pkg::fts_cycle_s         idle_cyc;
  fts_pkg::fts_kind_e          load_kind;
  logic                        qual_edge;
  logic                        load;
  logic [`FTS_BURST_W-1:0]     beat_next;
  logic [`FTS_BURST_W-1:0]     burst_low;

  assign ctrl = '{cs1_n: chip_select_1_n, cs2: chip_select_2, cs3_n: chip_select_3_n,
                  adv_load_n: advance_or_load_n, write_enable_n: write_enable_n,
                  clock_qualify_n: clock_qualify_n};

  // sleep wins: inputs and clock edges mean nothing while asleep
  assign qual_edge = !ctrl.clock_qualify_n && !asleep;
  assign load      = !ctrl.adv_load_n;

  assign load_kind = !selects_on(ctrl)    ? fts_pkg::cyc_idle :
                     ctrl.write_enable_n  ? fts_pkg::cyc_read :
                                            fts_pkg::cyc_write;

  assign beat_next = `FTS_BURST_W'(cur_q.beat + `FTS_BEAT_STEP);

  fts_burst u_burst (
    .start      (cur_q.start),
    .beat       (beat_next),
    .interleave (burst_order),
    .low_bits   (burst_low)
  );

  assign idle_cyc = '{kind: fts_pkg::cyc_idle, addr: '0, start: '0,
                      beat: `FTS_BEAT_FIRST, lane_n: `FTS_NO_LANES};

  assign load_cyc = '{kind: load_kind, addr: address,
                      start: address[`FTS_BURST_W-1:0],
                      beat: `FTS_BEAT_FIRST, lane_n: byte_lane_selects_n};

  // continue keeps the latched direction; idle stays idle
  assign cont_cyc = '{kind: cur_q.kind,
                      addr: {cur_q.addr[`FTS_ADDR_W-1:`FTS_BURST_W], burst_low},
                      start: cur_q.start,
                      beat: beat_next, lane_n: byte_lane_selects_n};

  assign next_cyc = load ? load_cyc : cont_cyc;

  // a pending access is dropped on sleep entry
  assign cur_d = asleep    ? idle_cyc :
                 qual_edge ? next_cyc :
                             cur_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= '{kind: fts_pkg::cyc_idle, addr: '0, start: '0,
                 beat: `FTS_BEAT_FIRST, lane_n: `FTS_NO_LANES};
    end else begin
      cur_q <= cur_d;
    end
  end

  // ****************************************
  // array access
  // ****************************************
  logic [`FTS_DATA_W-1:0]  wr_word;
  logic [`FTS_DATA_W-1:0]  rd_word;
  logic                    wr_en;
  logic                    rd_en;

  genvar g;
  generate
    for (g = 0; g < `FTS_LANES; g = g + 1) begin : pack
      assign wr_word[g*`FTS_LANE_W +: `FTS_LANE_W] =
        {parity_io_i[g], dq_i[g*`FTS_BYTE_W +: `FTS_BYTE_W]};
      assign dq_o[g*`FTS_BYTE_W +: `FTS_BYTE_W] =
        rd_word[g*`FTS_LANE_W +: `FTS_BYTE_W];
      assign parity_io_o[g] = rd_word[g*`FTS_LANE_W + `FTS_BYTE_W];
    end
  endgenerate

  // data phase of a write lands on the next qualified edge
  assign wr_en = qual_edge && (cur_q.kind == fts_pkg::cyc_write)
                 && (cur_q.lane_n != `FTS_NO_LANES);
  assign rd_en = qual_edge && (next_cyc.kind == fts_pkg::cyc_read);

  fts_mem u_mem (
    .clk     (clk),
    .rd_en   (rd_en),
    .rd_addr (next_cyc.addr),
    .wr_en   (wr_en),
    .wr_addr (cur_q.addr),
    .wr_lane (~cur_q.lane_n),
    .wr_data (wr_word),
    .rd_data (rd_word)
  );

  // ****************************************
  // output drive
  // ****************************************
  logic drive;

  // output enable is unclocked; write and idle cycles mask it
  assign drive = rst_n && !asleep
                 && (cur_q.kind == fts_pkg::cyc_read)
                 && !output_enable_n;
  assign dq_oe        = drive;
  assign parity_io_oe = drive;

  // ****************************************
  // checks
  // ****************************************
  sleep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sleep_request) ##1 sleep_request |=> sleep_active)
    else $error("sleep not reached two cycles after request");

  sleep_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sleep_request) ##1 !sleep_request |=> !sleep_active)
    else $error("sleep not left two cycles after release");

  sleep_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_active |-> !dq_oe && !parity_io_oe && !wr_en && !rd_en)
    else $error("activity while asleep");

  sleep_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_active |=> cur_q.kind == fts_pkg::cyc_idle)
    else $error("cycle survived sleep");

  stall_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    clock_qualify_n && !sleep_active |=> $stable(cur_q) && !$past(wr_en))
    else $error("state moved on a stalled edge");

  write_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    cur_q.kind == fts_pkg::cyc_write |-> !dq_oe && !parity_io_oe)
    else $error("pins driven in a write cycle");

  read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    dq_oe == (cur_q.kind == fts_pkg::cyc_read && !output_enable_n && !sleep_active))
    else $error("read drive does not follow output enable");

  linear_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && advance_or_load_n && !burst_order
      && cur_q.kind != fts_pkg::cyc_idle
    |=> cur_q.addr[1:0] == 2'($past(cur_q.addr[1:0]) + 2'h1))
    else $error("linear burst step wrong");

  mixed_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && advance_or_load_n && burst_order
      && cur_q.kind != fts_pkg::cyc_idle
    |=> cur_q.addr[1:0] == ($past(cur_q.start) ^ 2'($past(cur_q.beat) + 2'h1)))
    else $error("interleaved burst step wrong");

  begin_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && !advance_or_load_n && selects_on(ctrl) && write_enable_n
    |=> cur_q.kind == fts_pkg::cyc_read && cur_q.addr == $past(address))
    else $error("read not started");

  dir_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && advance_or_load_n |=> $stable(cur_q.kind))
    else $error("burst direction changed");

  abort_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && cur_q.kind == fts_pkg::cyc_write && cur_q.lane_n == `FTS_NO_LANES
    |-> !wr_en)
    else $error("aborted write touched memory");

  write_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && cur_q.kind == fts_pkg::cyc_write && cur_q.lane_n != `FTS_NO_LANES
    |-> wr_en)
    else $error("write data not taken");

  idle_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
    qual_edge && advance_or_load_n && cur_q.kind == fts_pkg::cyc_idle
    |=> cur_q.kind == fts_pkg::cyc_idle && !dq_oe)
    else $error("continue left deselect");

endmodule

// file: src/fts_params.svh
`ifndef FTS_PARAMS_SVH
`define FTS_PARAMS_SVH

// array shape
`define FTS_ADDR_W      17
`define FTS_DEPTH       131072
`define FTS_LANES       4
`define FTS_BYTE_W      8
`define FTS_LANE_W      9
`define FTS_DQ_W        32
`define FTS_DATA_W      36
`define FTS_BURST_W     2

// byte selects all high means a write abort
`define FTS_NO_LANES    4'hf
`define FTS_BEAT_FIRST  2'h0
`define FTS_BEAT_STEP   2'h1

// timing
`define FTS_CLK_PERIOD_NS      25
`define FTS_SLEEP_ENTRY_NS     50
`define FTS_SLEEP_RECOVERY_NS  50
`define FTS_SLEEP_CYC          (`FTS_SLEEP_ENTRY_NS / `FTS_CLK_PERIOD_NS)
`define FTS_RECOVERY_CYC       \
  ((`FTS_SLEEP_RECOVERY_NS + `FTS_CLK_PERIOD_NS - 1) / `FTS_CLK_PERIOD_NS)
`define FTS_RST_STAGES         2

`endif

// file: src/fts_pkg.sv
`include "fts_params.svh"

package fts_pkg;

  typedef enum logic [1:0] {
    cyc_idle,
    cyc_read,
    cyc_write
  } fts_kind_e;

  typedef struct packed {
    fts_kind_e                 kind;
    logic [`FTS_ADDR_W-1:0]    addr;
    logic [`FTS_BURST_W-1:0]   start;
    logic [`FTS_BURST_W-1:0]   beat;
    logic [`FTS_LANES-1:0]     lane_n;
  } fts_cycle_s;

  typedef struct packed {
    logic                      cs1_n;
    logic                      cs2;
    logic                      cs3_n;
    logic                      adv_load_n;
    logic                      write_enable_n;
    logic                      clock_qualify_n;
  } fts_ctrl_s;

endpackage

// file: src/fts_mem.sv
`timescale 1ns/10ps
`include "fts_params.svh"

module fts_mem (
  input  wire logic                    clk,
  input  wire logic                    rd_en,
  input  wire logic [`FTS_ADDR_W-1:0]  rd_addr,
  input  wire logic                    wr_en,
  input  wire logic [`FTS_ADDR_W-1:0]  wr_addr,
  input  wire logic [`FTS_LANES-1:0]   wr_lane,
  input  wire logic [`FTS_DATA_W-1:0]  wr_data,
  output logic      [`FTS_DATA_W-1:0]  rd_data
);

  // ****************************************
  // one array per lane, byte and parity kept together
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `FTS_LANES; g = g + 1) begin : lane
      logic [`FTS_LANE_W-1:0] store [0:`FTS_DEPTH-1];
      logic [`FTS_LANE_W-1:0] rd_q;
      logic                   wr_hit;
      logic                   bypass;

      assign wr_hit = wr_en && wr_lane[g];
      // read after write to the same word sees the new byte
      assign bypass = wr_hit && (wr_addr == rd_addr);

      always_ff @(posedge clk) begin
        if (wr_hit) begin
          store[wr_addr] <= wr_data[g*`FTS_LANE_W +: `FTS_LANE_W];
        end
      end

      always_ff @(posedge clk) begin
        if (rd_en) begin
          rd_q <= bypass ? wr_data[g*`FTS_LANE_W +: `FTS_LANE_W] : store[rd_addr];
        end
      end

      assign rd_data[g*`FTS_LANE_W +: `FTS_LANE_W] = rd_q;
    end
  endgenerate

endmodule

// file: src/fts_burst.sv
`timescale 1ns/10ps
`include "fts_params.svh"

module fts_burst (
  input  wire logic [`FTS_BURST_W-1:0]  start,
  input  wire logic [`FTS_BURST_W-1:0]  beat,
  input  wire logic                     interleave,
  output logic      [`FTS_BURST_W-1:0]  low_bits
);

  logic [`FTS_BURST_W-1:0] linear_bits;
  logic [`FTS_BURST_W-1:0] mixed_bits;

  // sum wraps modulo four by width
  assign linear_bits = `FTS_BURST_W'(start + beat);
  assign mixed_bits  = start ^ beat;
  assign low_bits    = interleave ? mixed_bits : linear_bits;

endmodule

// file: tb/fts_ctl_model.sv
`timescale 1ns/10ps
`include "fts_params.svh"

// ****************
// controller model
// ****************
module fts_ctl_model (
  input  wire logic                    clk,
  output fts_pkg::fts_ctrl_s           ctrl,
  output logic [`FTS_LANES-1:0]        lanes_n,
  output logic [`FTS_ADDR_W-1:0]       addr,
  output logic [`FTS_DATA_W-1:0]       wdata
);
  initial begin
    ctrl = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    lanes_n = `FTS_NO_LANES;
    addr = '0;
    wdata = '0;
  end

  // one qualified or stalled edge per call; caller sits just after a rising edge
  task automatic op(input logic ld_n, input logic wr_n, input logic sel, input logic q_n,
                    input logic [`FTS_LANES-1:0] ln, input logic [`FTS_ADDR_W-1:0] a,
                    input logic drv, input logic [`FTS_DATA_W-1:0] d);
    ctrl = '{!sel, sel, !sel, ld_n, wr_n, q_n};
    lanes_n = ln;
    addr = a;
    // an undriven data bus must not look like the last value
    wdata = drv ? d : ~wdata;
    @(posedge clk);
    #2;
  endtask
endmodule

// file: tb/fts_top_tb.sv
`timescale 1ns/10ps
`include "fts_params.svh"

module fts_top_tb;
  logic                     clk = 1'b0;
  logic                     reset_n = 1'b0;
  logic                     sleep_request = 1'b0;
  logic                     oe_n = 1'b0;
  logic                     border = 1'b0;
  fts_pkg::fts_ctrl_s       ctrl;
  logic [`FTS_LANES-1:0]    lanes_n;
  logic [`FTS_ADDR_W-1:0]   addr;
  logic [`FTS_DATA_W-1:0]   wdata;
  logic [`FTS_DQ_W-1:0]     dq_o;
  logic [`FTS_LANES-1:0]    par_o;
  logic                     dq_oe;
  logic                     par_oe;
  logic                     sleep_active;
  logic [35:0]              exp_mem [int];
  int                       miscompares = 0;
  int                       checks = 0;

  always #12.5 clk = ~clk;

  fts_ctl_model ctl (.clk(clk), .ctrl(ctrl), .lanes_n(lanes_n), .addr(addr), .wdata(wdata));

  fts_top dut (
    .clk(clk), .reset_n(reset_n), .sleep_request(sleep_request),
    .chip_select_1_n(ctrl.cs1_n), .chip_select_2(ctrl.cs2), .chip_select_3_n(ctrl.cs3_n),
    .advance_or_load_n(ctrl.adv_load_n), .write_enable_n(ctrl.write_enable_n),
    .byte_lane_selects_n(lanes_n), .clock_qualify_n(ctrl.clock_qualify_n),
    .output_enable_n(oe_n), .burst_order(border), .address(addr),
    .dq_i(wdata[31:0]), .dq_o(dq_o), .dq_oe(dq_oe), .parity_io_i(wdata[35:32]),
    .parity_io_o(par_o), .parity_io_oe(par_oe), .sleep_active(sleep_active)
  );

  // ***********
  // helpers
  // ***********
  task automatic check(input logic [35:0] seen, input logic [35:0] want, input string msg);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, want);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [16:0] baddr(logic [16:0] a, logic il, int j);
    logic [1:0] s;
    s = il ? a[1:0] ^ 2'(j) : a[1:0] + 2'(j);
    return {a[16:2], s};
  endfunction

  function automatic logic [35:0] pat(logic [16:0] a, int j);
    return {4'(j) ^ a[3:0], 8'(j), a, 7'h2b};
  endfunction

  function automatic logic [35:0] want(logic [16:0] a);
    return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : 36'bx;
  endfunction

  // ***********
  // scenarios
  // ***********
  // data of beat k goes out with the command of beat k+1; last beat closes with deselect
  task automatic burst_wr(input logic [16:0] a, input logic il, input logic [15:0] lns);
    logic [35:0] m;
    logic [3:0]  ln;
    border = il;
    oe_n = 1'b0;
    for (int k = 0; k < 5; k++) begin
      ln = (k < 4) ? lns[4*k+:4] : 4'h0;
      ctl.op(k != 0 && k != 4, 1'b0, k < 4, 1'b0, ln, a, k > 0, pat(a, k - 1));
      if (k > 0) begin
        m = want(baddr(a, il, k - 1));
        for (int b = 0; b < 4; b++) begin
          if (!lns[4*(k-1)+b]) begin
            m[8*b+:8] = pat(a, k - 1) >> (8 * b);
            m[32+b] = pat(a, k - 1) >> (32 + b);
          end
        end
        exp_mem[int'(baddr(a, il, k - 1))] = m;
      end
      check(36'(dq_oe), 36'h0, "drive during write");
    end
  endtask

  // continue beats carry write enable low and selects off: both ignored
  task automatic burst_rd(input logic [16:0] a, input logic il, input logic oe);
    border = il;
    oe_n = oe;
    for (int k = 0; k < 4; k++) begin
      ctl.op(k != 0, k == 0, k == 0, 1'b0, 4'h0, a, 1'b0, 36'h0);
      check(36'(dq_oe), 36'(!oe), "read drive");
      check(36'(par_oe), 36'(!oe), "parity drive");
      if (!oe) check({par_o, dq_o}, want(baddr(a, il, k)), "read data");
      if (k == 1 && !oe) begin
        ctl.op(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, a + 17'h8, 1'b1, 36'h0);
        check({par_o, dq_o}, want(baddr(a, il, 1)), "stall data");
        oe_n = 1'b1;
        #1 check(36'(dq_oe), 36'h0, "async oe off");
        oe_n = 1'b0;
        #1 check(36'(dq_oe), 36'h1, "async oe on");
      end
    end
  endtask

  task automatic desel_cont(input logic [16:0] a);
    oe_n = 1'b0;
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    ctl.op(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    check(36'(dq_oe), 36'h0, "continue after deselect");
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b1, 36'hf_ffff_ffff);
    burst_rd(a, 1'b0, 1'b0);
  endtask

  task automatic sleep_test(input logic [16:0] a);
    oe_n = 1'b0;
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    sleep_request = 1'b1;
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    check(36'(sleep_active), 36'h0, "sleep after one edge");
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    check(36'(sleep_active), 36'h1, "sleep after two edges");
    ctl.op(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, a, 1'b0, 36'h0);
    ctl.op(1'b0, 1'b1, 1'b1, 1'b0, 4'h0, a, 1'b1, 36'h0);
    check(36'(dq_oe), 36'h0, "drive while asleep");
    sleep_request = 1'b0;
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    check(36'(sleep_active), 36'h1, "wake after one edge");
    ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    check(36'(sleep_active), 36'h0, "wake after two edges");
    repeat (2) ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, a, 1'b0, 36'h0);
    burst_rd(a, 1'b1, 1'b0);
  endtask

  initial begin
    #(100000 * 25);
    miscompares++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #2 check(36'(dq_oe), 36'h0, "power-up drive");
    check(36'(sleep_active), 36'h0, "power-up sleep");
    burst_wr(17'h00100, 1'b0, 16'h0000);
    burst_wr(17'h00104, 1'b1, 16'h0000);
    burst_wr(17'h00102, 1'b1, 16'h5fe0);
    burst_wr(17'h00105, 1'b0, 16'h1248);
    desel_cont(17'h00100);
    burst_rd(17'h00102, 1'b1, 1'b0);
    burst_rd(17'h00105, 1'b0, 1'b0);
    burst_rd(17'h00107, 1'b1, 1'b1);
    sleep_test(17'h00104);
    stop_test;
  end
endmodule
